// ==== apc_ctrl.sv ====
// Converter power-down, result format and input channel control with an APB slave
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module apc_ctrl
  import apc_pkg::*;
(
  input  wire logic                    CLOCK,
  input  wire logic                    RST_N,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [APC_ADDR_W-1:0]   PADDR,
  input  wire logic [APC_DATA_W-1:0]   PWDATA,
  output logic      [APC_DATA_W-1:0]   PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    CONV_DONE,
  input  wire logic [APC_RESULT_W-1:0] CONV_DATA,
  output logic                         CONV_ENABLE,
  output logic      [APC_CHANNELS-1:0] INPUT_ENABLE,
  output logic                         REFERENCE_ROUTE,
  output logic      [APC_SELECT_W-1:0] INPUT_SELECT_LOW
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    converter_power_down;
    logic                    result_justify_select;
    logic [APC_SELECT_W-1:0] input_select_low;
    logic                    internal_reference_route;
    logic [APC_RESULT_W-1:0] result;
    logic                    pready;
    logic                    pslverr;
    logic [APC_DATA_W-1:0]   prdata;
    logic                    conv_enable;
    logic [APC_CHANNELS-1:0] input_enable;
    logic                    reference_route;
    logic [APC_SELECT_W-1:0] select_out;
  } apc_state_s;

  apc_state_s                s;
  apc_state_s                next_s;
  logic [APC_CHANNELS-1:0]   chan_hot;
  logic [APC_BYTE_W-1:0]     high_byte;
  logic [APC_BYTE_W-1:0]     low_byte;
  logic                      access;
  logic                      fire;

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  apc_result_format u_format (
    .result        (s.result),
    .justify_right (s.result_justify_select),
    .high_byte     (high_byte),
    .low_byte      (low_byte)
  );

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < APC_CHANNELS; g++)
    begin : g_chan
      assign chan_hot[g] = (s.input_select_low == APC_SELECT_W'(g));
    end
  endgenerate

  assign access = PSEL && PENABLE;
  assign fire   = access && s.pready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [APC_DATA_W-1:0] rd;
    logic                  err;
    rd     = '0;
    err    = 1'b0;
    next_s = s;

    // Read data and address decode
    case (PADDR)
      APC_OFF_CTRL_ZERO:
      begin
        rd[APC_POWER_DOWN_BIT] = s.converter_power_down;
        rd[APC_JUSTIFY_BIT]    = s.result_justify_select;
        rd[APC_SELECT_LSB +: APC_SELECT_W] = s.input_select_low;
        rd[APC_UNUSED_BIT]     = 1'b0;
      end
      APC_OFF_CTRL_ONE:
      begin
        rd[APC_REF_ROUTE_BIT]  = s.internal_reference_route;
      end
      APC_OFF_RESULT_HIGH:
      begin
        rd[APC_BYTE_W-1:0]     = high_byte;
      end
      APC_OFF_RESULT_LOW:
      begin
        rd[APC_BYTE_W-1:0]     = low_byte;
      end
      default:
      begin
        err = 1'b1;
      end
    endcase

    // One wait cycle, then the answer stands for a single cycle
    next_s.pready  = access && !s.pready;
    next_s.pslverr = (access && !s.pready) ? err : 1'b0;
    next_s.prdata  = (access && !s.pready && !PWRITE) ? rd : '0;

    // Writes land only at the completing edge
    if (fire && PWRITE)
    begin
      case (PADDR)
        APC_OFF_CTRL_ZERO:
        begin
          next_s.converter_power_down  = PWDATA[APC_POWER_DOWN_BIT];
          next_s.result_justify_select = PWDATA[APC_JUSTIFY_BIT];
          next_s.input_select_low      = PWDATA[APC_SELECT_LSB +: APC_SELECT_W];
        end
        APC_OFF_CTRL_ONE:
        begin
          next_s.internal_reference_route = PWDATA[APC_REF_ROUTE_BIT];
        end
        default:
        begin
          next_s.result = s.result;
        end
      endcase
    end

    // Results are taken only from a powered converter
    if (CONV_DONE && !s.converter_power_down)
    begin
      next_s.result = CONV_DATA;
    end

    // Analogue side controls
    next_s.conv_enable     = !s.converter_power_down;
    next_s.reference_route = !s.converter_power_down && s.internal_reference_route;
    next_s.select_out      = s.input_select_low;
    if (s.converter_power_down || s.internal_reference_route)
    begin
      next_s.input_enable = '0;
    end
    else
    begin
      next_s.input_enable = chan_hot;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s                          <= '0;
      s.converter_power_down     <= APC_RST_POWER_DOWN;
      s.result_justify_select    <= APC_RST_JUSTIFY;
      s.input_select_low         <= APC_RST_SELECT;
      s.internal_reference_route <= APC_RST_REF_ROUTE;
      s.result                   <= APC_RST_RESULT;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign PRDATA           = s.prdata;
  assign PREADY           = s.pready;
  assign PSLVERR          = s.pslverr;
  assign CONV_ENABLE      = s.conv_enable;
  assign INPUT_ENABLE     = s.input_enable;
  assign REFERENCE_ROUTE  = s.reference_route;
  assign INPUT_SELECT_LOW = s.select_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence seq_setup;
    PSEL && !PENABLE;
  endsequence

  sequence seq_access;
    PSEL && PENABLE;
  endsequence

  sequence seq_read_ctrl_zero;
    PSEL && PENABLE && PREADY && !PWRITE && (PADDR == APC_OFF_CTRL_ZERO);
  endsequence

  sequence seq_write_ctrl_zero;
    PSEL && PENABLE && PREADY && PWRITE && (PADDR == APC_OFF_CTRL_ZERO);
  endsequence

  sequence seq_write_ctrl_one;
    PSEL && PENABLE && PREADY && PWRITE && (PADDR == APC_OFF_CTRL_ONE);
  endsequence

  sequence seq_read_result;
    PSEL && PENABLE && PREADY && !PWRITE
    && ((PADDR == APC_OFF_RESULT_HIGH) || (PADDR == APC_OFF_RESULT_LOW));
  endsequence

  sequence seq_read_result_low;
    PSEL && PENABLE && PREADY && !PWRITE && (PADDR == APC_OFF_RESULT_LOW);
  endsequence

  AST_APB_ANSWER: assert property (seq_setup ##1 seq_access |-> ##1 PREADY) else
    $error("APB answer not given in the second access cycle");

  AST_POWERED_RUN: assert property (!s.converter_power_down |=> CONV_ENABLE) else
    $error("Converter not enabled while powered");

  AST_POWER_OFF: assert property (s.converter_power_down |=>
    !CONV_ENABLE && (INPUT_ENABLE == '0) && !REFERENCE_ROUTE) else
    $error("Converter still active while powered down");

  AST_NO_CAPTURE_OFF: assert property (CONV_DONE && s.converter_power_down |=>
    s.result == $past(s.result)) else
    $error("Result taken from a powered down converter");

  AST_LEFT_JUSTIFY_BYTES: assert property (!s.result_justify_select |->
    (high_byte == s.result[11:4]) && (low_byte[3:0] == 4'h0)
    && (low_byte[7:4] == s.result[3:0])) else
    $error("Left justified bytes wrong");

  AST_RIGHT_JUSTIFY_BYTES: assert property (s.result_justify_select |->
    (high_byte == {4'h0, s.result[11:8]}) && (low_byte == s.result[7:0])) else
    $error("Right justified bytes wrong");

  AST_CHANNEL_SELECT: assert property (!s.converter_power_down
    && !s.internal_reference_route |=>
    INPUT_ENABLE == (8'h01 << $past(s.input_select_low))) else
    $error("Wrong analogue input routed");

  AST_REFERENCE: assert property (!s.converter_power_down
    && s.internal_reference_route |=> REFERENCE_ROUTE && (INPUT_ENABLE == '0)) else
    $error("Internal reference not routed");

  AST_CAPTURE: assert property (CONV_DONE && !s.converter_power_down |=>
    s.result == $past(CONV_DATA)) else
    $error("Conversion result not held");

  AST_RIGHT_PAD_READ: assert property (PSEL && PENABLE && PREADY && !PWRITE
    && (PADDR == APC_OFF_RESULT_HIGH) && s.result_justify_select |->
    PRDATA[7:4] == 4'h0) else
    $error("Unused result bits not zero");

  AST_BIT3_ZERO: assert property (seq_write_ctrl_zero ##0 PWDATA[APC_UNUSED_BIT] ##1
    (!PSEL [*1]) ##1 seq_setup ##1 seq_access ##1 seq_read_ctrl_zero |->
    !PRDATA[APC_UNUSED_BIT]) else
    $error("Unused control bit reads as one");

  AST_BIT3_READ: assert property (seq_read_ctrl_zero |-> !PRDATA[APC_UNUSED_BIT]) else
    $error("Unused control bit reads as one");

  AST_LEFT_PAD_READ: assert property (seq_read_result_low ##0
    !s.result_justify_select |-> PRDATA[3:0] == 4'h0) else
    $error("Unused low result bits not zero");

  AST_RESULT_UPPER_ZERO: assert property (seq_read_result |-> PRDATA[31:8] == '0) else
    $error("Result read carries bits above the byte");

  AST_POWER_UP_WRITE: assert property (seq_write_ctrl_zero ##0
    !PWDATA[APC_POWER_DOWN_BIT] |=> !s.converter_power_down ##1 CONV_ENABLE) else
    $error("Clearing the power-down bit did not enable the converter");

  AST_POWER_DOWN_WRITE: assert property (seq_write_ctrl_zero ##0
    PWDATA[APC_POWER_DOWN_BIT] |=> s.converter_power_down ##1 !CONV_ENABLE) else
    $error("Setting the power-down bit did not stop the converter");

  AST_REF_WRITE: assert property (seq_write_ctrl_one ##0
    PWDATA[APC_REF_ROUTE_BIT] |=> s.internal_reference_route ##1 (INPUT_ENABLE == '0)) else
    $error("Reference route write did not take over the converter input");

  AST_SELECT_OUT: assert property (RST_N |=>
    INPUT_SELECT_LOW == $past(s.input_select_low)) else
    $error("Select copy does not follow the control register");

endmodule : apc_ctrl

`default_nettype wire

// ==== apc_ctrl_tb_top.sv ====
// Self-checking testbench for the converter power, format and channel control block
`timescale 1ns/10ps
`default_nettype none

module apc_ctrl_tb_top
  import apc_pkg::*;
;
  logic                    clock;
  logic                    rst_n;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [APC_ADDR_W-1:0]   paddr;
  logic [APC_DATA_W-1:0]   pwdata;
  logic [APC_DATA_W-1:0]   prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    conv_done;
  logic [APC_RESULT_W-1:0] conv_data;
  logic                    conv_enable;
  logic [APC_CHANNELS-1:0] input_enable;
  logic                    reference_route;
  logic [APC_SELECT_W-1:0] input_select_low;
  int                      err_count;
  int                      n_compared;
  int                      pd;
  int                      js;
  int                      sel;
  int                      rr;
  int                      res;
  logic [31:0]             rd;
  logic                    er;

  apc_ctrl u_apc_ctrl (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
    .CONV_ENABLE(conv_enable), .INPUT_ENABLE(input_enable),
    .REFERENCE_ROUTE(reference_route), .INPUT_SELECT_LOW(input_select_low));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    check("access cycles", n, 32'h2);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check("read data", rd, exp);
    check("slverr", {31'h0, er}, 32'h0);
  endtask : rchk

  task automatic wr0(input int d);
    apb(1'b1, APC_OFF_CTRL_ZERO, d);
    pd = (d >> 5) & 1;
    js = (d >> 4) & 1;
    sel = d & 7;
  endtask : wr0

  task automatic outs();
    @(posedge clock);
    check("conv enable", {31'h0, conv_enable}, 32'(pd == 0));
    check("input enable", {24'h0, input_enable}, (pd != 0 || rr != 0) ? 0 : 1 << sel);
    check("reference", {31'h0, reference_route}, 32'(rr != 0 && pd == 0));
    check("select", {29'h0, input_select_low}, sel);
  endtask : outs

  task automatic convert(input int d);
    conv_done <= 1'b1;
    conv_data <= d[11:0];
    if (pd == 0)
      res = d & 32'hFFF;
    @(posedge clock);
    conv_done <= 1'b0;
    @(posedge clock);
  endtask : convert

  task automatic results();
    rchk(APC_OFF_RESULT_HIGH, js ? (res >> 8) & 32'hF : (res >> 4) & 32'hFF);
    rchk(APC_OFF_RESULT_LOW, js ? res & 32'hFF : (res & 32'hF) << 4);
  endtask : results

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, conv_done} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_data = 12'h000;
    err_count = 0;
    n_compared = 0;
    {pd, js, sel, rr, res} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd0};
    void'($urandom(89));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    outs();
    rchk(APC_OFF_CTRL_ZERO, 32'h20);
    rchk(APC_OFF_CTRL_ONE, 32'h0);
    convert($urandom);
    results();
    $display("test reset and power-down done");
    for (int i = 0; i < 8; i++)
    begin
      wr0(32'h8 | i | (($urandom & 1) << 4) | 32'hFFFFFF00);
      rchk(APC_OFF_CTRL_ZERO, (js << 4) | sel);
      outs();
    end
    $display("test channel select done");
    for (int k = 0; k < 6; k++)
    begin
      wr0((k & 1) << 4 | sel);
      convert(k < 2 ? (k ? 32'hFFF : 32'h0) : $urandom);
      results();
    end
    $display("test result format done");
    apb(1'b1, APC_OFF_CTRL_ONE, 32'h80 | ($urandom & 32'h7F));
    rr = 1;
    outs();
    rchk(APC_OFF_CTRL_ONE, 32'h80);
    apb(1'b1, APC_OFF_CTRL_ONE, 32'h0);
    rr = 0;
    outs();
    $display("test reference route done");
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped slverr", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, APC_OFF_RESULT_HIGH, 32'hFF);
    check("read-only slverr", {31'h0, er}, 32'h0);
    results();
    $display("test unmapped and read-only done");
    wr0(32'h20);
    outs();
    convert($urandom);
    results();
    $display("test power-down done");
    wrap_up();
  end
endmodule : apc_ctrl_tb_top

`default_nettype wire

// ==== apc_pkg.sv ====
// Package of constants for the converter power, format and channel control block
`default_nettype none

package apc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          APC_ADDR_W          = 8;
  localparam int          APC_DATA_W          = 32;
  localparam logic [7:0]  APC_OFF_CTRL_ZERO   = 8'h00;
  localparam logic [7:0]  APC_OFF_CTRL_ONE    = 8'h04;
  localparam logic [7:0]  APC_OFF_RESULT_HIGH = 8'h08;
  localparam logic [7:0]  APC_OFF_RESULT_LOW  = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          APC_POWER_DOWN_BIT  = 5;
  localparam int          APC_JUSTIFY_BIT     = 4;
  localparam int          APC_UNUSED_BIT      = 3;
  localparam int          APC_SELECT_LSB      = 0;
  localparam int          APC_SELECT_W        = 3;
  localparam int          APC_REF_ROUTE_BIT   = 7;

  // ----------------------------------------------------------------
  // Converter geometry
  // ----------------------------------------------------------------
  localparam int          APC_RESULT_W        = 12;
  localparam int          APC_CHANNELS        = 8;
  localparam int          APC_BYTE_W          = 8;
  localparam int          APC_PAD_W           = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        APC_RST_POWER_DOWN  = 1'b1;
  localparam logic        APC_RST_JUSTIFY     = 1'b0;
  localparam logic [2:0]  APC_RST_SELECT      = 3'h0;
  localparam logic        APC_RST_REF_ROUTE   = 1'b0;
  localparam logic [11:0] APC_RST_RESULT      = 12'h000;

endpackage : apc_pkg

`default_nettype wire

// ==== apc_result_format.sv ====
// Places the stored conversion result into the high and low result bytes
`timescale 1ns/10ps
`default_nettype none

module apc_result_format
  import apc_pkg::*;
(
  input  wire logic [APC_RESULT_W-1:0] result,
  input  wire logic                    justify_right,
  output logic      [APC_BYTE_W-1:0]   high_byte,
  output logic      [APC_BYTE_W-1:0]   low_byte
);

  // ----------------------------------------------------------------
  // Justification
  // ----------------------------------------------------------------
  always_comb
  begin
    if (justify_right)
    begin
      high_byte = {{APC_PAD_W{1'b0}}, result[11:8]};
      low_byte  = result[7:0];
    end
    else
    begin
      high_byte = result[11:4];
      low_byte  = {result[3:0], {APC_PAD_W{1'b0}}};
    end
  end

endmodule : apc_result_format

`default_nettype wire
